/* File: dpr_dual_port_ram.v */
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`include "dpr_consts.vh"

module dpr_dual_port_ram #(
	parameter WIDTH_A = 16,
	parameter WIDTH_B = 16,
	parameter AW_A = (WIDTH_A == 1) ? 12 : (WIDTH_A == 2) ? 11 : (WIDTH_A == 4) ? 10 :
		(WIDTH_A == 8) ? 9 : 8,
	parameter AW_B = (WIDTH_B == 1) ? 12 : (WIDTH_B == 2) ? 11 : (WIDTH_B == 4) ? 10 :
		(WIDTH_B == 8) ? 9 : 8,
	parameter [255:0] INIT_00 = 256'h0,
	parameter [255:0] INIT_01 = 256'h0,
	parameter [255:0] INIT_02 = 256'h0,
	parameter [255:0] INIT_03 = 256'h0,
	parameter [255:0] INIT_04 = 256'h0,
	parameter [255:0] INIT_05 = 256'h0,
	parameter [255:0] INIT_06 = 256'h0,
	parameter [255:0] INIT_07 = 256'h0,
	parameter [255:0] INIT_08 = 256'h0,
	parameter [255:0] INIT_09 = 256'h0,
	parameter [255:0] INIT_0A = 256'h0,
	parameter [255:0] INIT_0B = 256'h0,
	parameter [255:0] INIT_0C = 256'h0,
	parameter [255:0] INIT_0D = 256'h0,
	parameter [255:0] INIT_0E = 256'h0,
	parameter [255:0] INIT_0F = 256'h0
) (
	input wire clk_i,
	input wire arst_n_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	output wire [31:0] prdata_o,
	output wire pready_o,
	output wire pslverr_o,
	input wire first_port_clock_i,
	input wire first_port_en_i,
	input wire first_port_we_i,
	input wire first_port_rst_i,
	input wire [AW_A-1:0] first_port_addr_i,
	input wire [WIDTH_A-1:0] first_port_write_data_i,
	output wire [WIDTH_A-1:0] first_port_read_data_o,
	input wire second_port_clock_i,
	input wire second_port_en_i,
	input wire second_port_we_i,
	input wire second_port_rst_i,
	input wire [AW_B-1:0] second_port_addr_i,
	input wire [WIDTH_B-1:0] second_port_write_data_i,
	output wire [WIDTH_B-1:0] second_port_read_data_o
);

	// ************************************************************
	// constants
	// ************************************************************
	localparam SA = AW_A + WIDTH_A + 4;
	localparam SB = AW_B + WIDTH_B + 4;
	localparam [4:0] WA5 = WIDTH_A;
	localparam [4:0] WB5 = WIDTH_B;
	// init values stacked so that value k lands on bits 256k and up
	localparam [`DPR_MEM_BITS-1:0] INIT_ALL = {INIT_0F, INIT_0E, INIT_0D, INIT_0C,
		INIT_0B, INIT_0A, INIT_09, INIT_08, INIT_07, INIT_06, INIT_05, INIT_04,
		INIT_03, INIT_02, INIT_01, INIT_00};

	// ************************************************************
	// helpers
	// ************************************************************
	// true when two bit ranges of the array share a cell
	function ovl;
		input [11:0] b1;
		input [4:0] w1;
		input [11:0] b2;
		input [4:0] w2;
		begin
			ovl = ({1'b0, b1} < ({1'b0, b2} + {8'h00, w2})) &&
				({1'b0, b2} < ({1'b0, b1} + {8'h00, w1}));
		end
	endfunction

	// true when an apb address hits a mapped register
	function mapped;
		input [11:0] a;
		begin
			mapped = (a == `DPR_OFF_CTRL) || (a == `DPR_OFF_STAT) ||
				(a == `DPR_OFF_WIN) || (a == `DPR_OFF_CNT);
		end
	endfunction

	// ************************************************************
	// state
	// ************************************************************
	reg [`DPR_MEM_BITS-1:0] mem_q;
	reg [SA-1:0] sa1_q;
	reg [SA-1:0] sa2_q;
	reg a_clk3_q;
	reg [SB-1:0] sb1_q;
	reg [SB-1:0] sb2_q;
	reg b_clk3_q;
	reg [WIDTH_A-1:0] a_out_q;
	reg [WIDTH_B-1:0] b_out_q;
	reg [11:0] a_last_q;
	reg [11:0] b_last_q;
	reg a_lwr_q;
	reg b_lwr_q;
	reg a_live_q;
	reg b_live_q;
	reg [7:0] a_age_q;
	reg [7:0] b_age_q;
	reg ctrl_en_q;
	reg [1:0] stat_q;
	reg [1:0] stat_d;
	reg [7:0] win_q;
	reg [31:0] cnt_q;
	reg [31:0] prdata_q;
	reg pready_q;
	reg pslverr_q;
	reg [31:0] rd_mux;

	// ************************************************************
	// port input synchronisers
	// ************************************************************
	// port clocks and their inputs ride the same two stages, so the
	// sampled data stays aligned with the detected port clock edge
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sa1_q <= {SA{1'b0}};
			sa2_q <= {SA{1'b0}};
			a_clk3_q <= 1'b0;
			sb1_q <= {SB{1'b0}};
			sb2_q <= {SB{1'b0}};
			b_clk3_q <= 1'b0;
		end else begin
			sa1_q <= {first_port_clock_i, first_port_en_i, first_port_we_i,
				first_port_rst_i, first_port_addr_i, first_port_write_data_i};
			sa2_q <= sa1_q;
			a_clk3_q <= sa2_q[SA-1];
			sb1_q <= {second_port_clock_i, second_port_en_i, second_port_we_i,
				second_port_rst_i, second_port_addr_i, second_port_write_data_i};
			sb2_q <= sb1_q;
			b_clk3_q <= sb2_q[SB-1];
		end
	end

	// ************************************************************
	// port decode
	// ************************************************************
	// all fields of one port come from the same stage on its edge
	wire a_edge = sa2_q[SA-1] & ~a_clk3_q;
	wire a_en = sa2_q[SA-2];
	wire a_we = sa2_q[SA-3];
	wire a_rst = sa2_q[SA-4];
	wire [AW_A-1:0] a_addr = sa2_q[AW_A+WIDTH_A-1:WIDTH_A];
	wire [WIDTH_A-1:0] a_wd = sa2_q[WIDTH_A-1:0];
	wire b_edge = sb2_q[SB-1] & ~b_clk3_q;
	wire b_en = sb2_q[SB-2];
	wire b_we = sb2_q[SB-3];
	wire b_rst = sb2_q[SB-4];
	wire [AW_B-1:0] b_addr = sb2_q[AW_B+WIDTH_B-1:WIDTH_B];
	wire [WIDTH_B-1:0] b_wd = sb2_q[WIDTH_B-1:0];

	// bit base of each access: address scaled by the port width
	wire [AW_A+15:0] a_sh = {a_addr, 16'h0000} >> (16 - (12 - AW_A));
	wire [AW_B+15:0] b_sh = {b_addr, 16'h0000} >> (16 - (12 - AW_B));
	wire [11:0] a_base = a_sh[11:0];
	wire [11:0] b_base = b_sh[11:0];

	// an enabled edge; a port in reset makes no memory access
	wire a_go = a_edge & a_en & ctrl_en_q;
	wire b_go = b_edge & b_en & ctrl_en_q;
	wire a_acc = a_go & ~a_rst;
	wire b_acc = b_go & ~b_rst;

	// ************************************************************
	// collision detection
	// ************************************************************
	// same cycle, or the other port touched the cell inside the window,
	// and at least one side of the pair is a write
	wire ov_now = ovl(a_base, WA5, b_base, WB5);
	wire c_now = a_acc & b_acc & ov_now & (a_we | b_we);
	wire c_a = a_acc & ~b_acc & b_live_q & (b_age_q < win_q) &
		ovl(a_base, WA5, b_last_q, WB5) & (a_we | b_lwr_q);
	wire c_b = b_acc & ~a_acc & a_live_q & (a_age_q < win_q) &
		ovl(b_base, WB5, a_last_q, WA5) & (b_we | a_lwr_q);
	wire ww = (c_now & a_we & b_we) | (c_a & a_we & b_lwr_q) |
		(c_b & b_we & a_lwr_q);
	wire wr = (c_now | c_a | c_b) & ~ww;
	wire any_c = c_now | c_a | c_b;

	// ************************************************************
	// memory array and port outputs
	// ************************************************************
	// one process owns the array; both ports act in the same cycle,
	// reads see the contents before either write of that cycle
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mem_q <= INIT_ALL;
			a_out_q <= {WIDTH_A{1'b0}};
			b_out_q <= {WIDTH_B{1'b0}};
		end else begin
			if (a_go) begin
				if (a_rst) begin
					a_out_q <= {WIDTH_A{1'b0}};
				end else if (a_we) begin
					mem_q[a_base +: WIDTH_A] <= a_wd;
					a_out_q <= a_wd;
				end else begin
					a_out_q <= mem_q[a_base +: WIDTH_A];
				end
			end
			if (b_go) begin
				if (b_rst) begin
					b_out_q <= {WIDTH_B{1'b0}};
				end else if (b_we) begin
					// in a same-cell double write this one lands last
					mem_q[b_base +: WIDTH_B] <= b_wd;
					b_out_q <= b_wd;
				end else begin
					b_out_q <= mem_q[b_base +: WIDTH_B];
				end
			end
		end
	end

	// ************************************************************
	// recent access tracking for the window
	// ************************************************************
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			a_last_q <= 12'h000;
			b_last_q <= 12'h000;
			a_lwr_q <= 1'b0;
			b_lwr_q <= 1'b0;
			a_live_q <= 1'b0;
			b_live_q <= 1'b0;
			a_age_q <= `DPR_AGE_MAX;
			b_age_q <= `DPR_AGE_MAX;
		end else begin
			if (a_acc) begin
				a_last_q <= a_base;
				a_lwr_q <= a_we;
				a_live_q <= 1'b1;
				a_age_q <= 8'h00;
			end else if (a_age_q != `DPR_AGE_MAX) begin
				a_age_q <= a_age_q + 8'h01;
			end
			if (b_acc) begin
				b_last_q <= b_base;
				b_lwr_q <= b_we;
				b_live_q <= 1'b1;
				b_age_q <= 8'h00;
			end else if (b_age_q != `DPR_AGE_MAX) begin
				b_age_q <= b_age_q + 8'h01;
			end
		end
	end

	// ************************************************************
	// apb slave
	// ************************************************************
	wire apb_setup = psel_i & ~penable_i;
	wire apb_done = psel_i & penable_i & pready_q;
	wire apb_wr = apb_done & pwrite_i & ~pslverr_q;

	// read mux for the setup cycle
	always @* begin
		rd_mux = 32'h0000_0000;
		case (paddr_i)
			`DPR_OFF_CTRL: rd_mux[`DPR_CTRL_EN] = ctrl_en_q;
			`DPR_OFF_STAT: rd_mux[1:0] = stat_q;
			`DPR_OFF_WIN: rd_mux[7:0] = win_q;
			`DPR_OFF_CNT: rd_mux = cnt_q;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// sticky collision flags, write one to clear, a new event wins
	always @* begin
		stat_d = stat_q;
		if (apb_wr && paddr_i == `DPR_OFF_STAT) begin
			stat_d = stat_q & ~pwdata_i[1:0];
		end
		if (ww) begin
			stat_d[`DPR_STAT_WW] = 1'b1;
		end
		if (wr) begin
			stat_d[`DPR_STAT_WR] = 1'b1;
		end
	end

	// answer one cycle after setup, registers change at the done edge
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			ctrl_en_q <= `DPR_CTRL_RST;
			stat_q <= `DPR_STAT_RST;
			win_q <= `DPR_WIN_RST;
			cnt_q <= `DPR_CNT_RST;
		end else begin
			stat_q <= stat_d;
			if (apb_setup) begin
				pready_q <= 1'b1;
				pslverr_q <= ~mapped(paddr_i);
				prdata_q <= rd_mux;
			end else begin
				pready_q <= 1'b0;
				pslverr_q <= 1'b0;
			end
			if (apb_wr && paddr_i == `DPR_OFF_CTRL) begin
				ctrl_en_q <= pwdata_i[`DPR_CTRL_EN];
			end
			if (apb_wr && paddr_i == `DPR_OFF_WIN) begin
				win_q <= pwdata_i[7:0];
			end
			if (any_c) begin
				cnt_q <= cnt_q + 32'h0000_0001;
			end else if (apb_wr && paddr_i == `DPR_OFF_CNT) begin
				cnt_q <= `DPR_CNT_RST;
			end
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign first_port_read_data_o = a_out_q;
	assign second_port_read_data_o = b_out_q;
	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;

endmodule // dpr_dual_port_ram

/* File: dpr_consts.vh */
`ifndef DPR_CONSTS_VH
`define DPR_CONSTS_VH

// ************************************************************
// memory geometry
// ************************************************************
`define DPR_MEM_BITS 4096
`define DPR_INIT_COUNT 16
`define DPR_INIT_BITS 256
`define DPR_BASE_BITS 12

// ************************************************************
// register byte offsets
// ************************************************************
`define DPR_OFF_CTRL 12'h000
`define DPR_OFF_STAT 12'h004
`define DPR_OFF_WIN 12'h008
`define DPR_OFF_CNT 12'h00C

// ************************************************************
// field positions
// ************************************************************
`define DPR_CTRL_EN 0
`define DPR_STAT_WW 0
`define DPR_STAT_WR 1

// ************************************************************
// reset values
// ************************************************************
`define DPR_CTRL_RST 1'b1
`define DPR_STAT_RST 2'h0
`define DPR_WIN_RST 8'h02
`define DPR_CNT_RST 32'h0000_0000
`define DPR_AGE_MAX 8'hFF

`endif

/* File: dpr_checker.sv */
`timescale 1ns/1ns
// ****
// bus and port checker
// ****
module dpr_checker #(
	parameter WIDTH_A = 16,
	parameter WIDTH_B = 16
) (
	input wire clk_i,
	input wire arst_n_i,
	input wire psel_i,
	input wire penable_i,
	input wire pready_o,
	input wire pslverr_o,
	input wire first_port_clock_i,
	input wire first_port_en_i,
	input wire first_port_we_i,
	input wire first_port_rst_i,
	input wire [WIDTH_A-1:0] first_port_write_data_i,
	input wire [WIDTH_A-1:0] first_port_read_data_o,
	input wire second_port_clock_i,
	input wire second_port_en_i,
	input wire second_port_we_i,
	input wire second_port_rst_i,
	input wire [WIDTH_B-1:0] second_port_write_data_i,
	input wire [WIDTH_B-1:0] second_port_read_data_o
);
	reg clkb_q;
	reg [3:0] age_b_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	// cycles since the last port b clock rise, saturating
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			clkb_q <= 1'b0;
			age_b_q <= 4'hF;
		end else begin
			clkb_q <= second_port_clock_i;
			if (second_port_clock_i && !clkb_q)
				age_b_q <= 4'h0;
			else if (age_b_q != 4'hF)
				age_b_q <= age_b_q + 4'h1;
		end
	end
	// zero wait states, one-cycle answer
	property p_ready_next;
		psel_i && !penable_i |=> pready_o;
	endproperty
	a_ready_next: assert property (p_ready_next) else $error("no answer after setup");
	property p_ready_pulse;
		pready_o |=> !pready_o;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
	property p_err_qual;
		pslverr_o |-> pready_o && psel_i && penable_i;
	endproperty
	a_err_qual: assert property (p_err_qual) else $error("pslverr outside access");
	// port outputs settle well before the next port edge
	property p_mirror_a;
		$rose(first_port_clock_i) && first_port_en_i && first_port_we_i && !first_port_rst_i
			|-> ##6 first_port_read_data_o == $past(first_port_write_data_i, 6);
	endproperty
	a_mirror_a: assert property (p_mirror_a) else $error("port a write not mirrored");
	property p_mirror_b;
		$rose(second_port_clock_i) && second_port_en_i && second_port_we_i && !second_port_rst_i
			|-> ##6 second_port_read_data_o == $past(second_port_write_data_i, 6);
	endproperty
	a_mirror_b: assert property (p_mirror_b) else $error("port b write not mirrored");
	property p_hold_a;
		$rose(first_port_clock_i) && !first_port_en_i |=> $stable(first_port_read_data_o)[*7];
	endproperty
	a_hold_a: assert property (p_hold_a) else $error("disabled port a output moved");
	property p_rst_a;
		$rose(first_port_clock_i) && first_port_en_i && first_port_rst_i
			|-> ##6 first_port_read_data_o == 0;
	endproperty
	a_rst_a: assert property (p_rst_a) else $error("port a output not cleared");
	property p_other_b;
		$changed(second_port_read_data_o) |-> age_b_q <= 4'h6;
	endproperty
	a_other_b: assert property (p_other_b) else $error("port b output moved on its own");
endmodule // dpr_checker

/* File: dpr_port_model.sv */
`timescale 1ns/1ns
// ****
// fabric user logic driving one port
// ****
module dpr_port_model (
	input wire clk_i,
	output logic pclk_o,
	output logic en_o,
	output logic we_o,
	output logic rst_o,
	output logic [7:0] addr_o,
	output logic [15:0] data_o
);
	// idle at time zero
	initial begin
		pclk_o = 1'b0;
		en_o = 1'b0;
		we_o = 1'b0;
		rst_o = 1'b0;
		addr_o = 8'h00;
		data_o = 16'h0000;
	end
	// one slow port clock pulse, inputs held around it
	task op(input logic e, w, r, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		en_o <= e;
		we_o <= w;
		rst_o <= r;
		addr_o <= a;
		data_o <= d;
		repeat (3) @(posedge clk_i);
		pclk_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		pclk_o <= 1'b0;
		repeat (4) @(posedge clk_i);
		// released lines show the inverse; calls spaced far apart
		en_o <= 1'b0;
		addr_o <= ~a;
		data_o <= ~d;
	endtask
endmodule // dpr_port_model

/* File: testbench.sv */
`timescale 1ns/1ns
module testbench;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, er;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0000_0000, rd;
	wire [31:0] prdata_o;
	wire pready_o, pslverr_o, ca, ea, wa, ra, cb, eb, wb, rb;
	wire [7:0] aa, ab;
	wire [15:0] da, qa, db, qb;
	wire [7:0] qb8;
	int n_fail = 0, tests_run = 0, cyc = 0;
	// ****
	// clock, design and port drivers
	// ****
	always #10 clk_i = ~clk_i;
	dpr_dual_port_ram #(.INIT_00(256'hA5C3), .INIT_01(256'h5A3C), .INIT_0F(256'h7E7E))
		i_dpr_dual_port_ram (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.first_port_clock_i(ca), .first_port_en_i(ea), .first_port_we_i(wa),
		.first_port_rst_i(ra), .first_port_addr_i(aa), .first_port_write_data_i(da),
		.first_port_read_data_o(qa), .second_port_clock_i(cb), .second_port_en_i(eb),
		.second_port_we_i(wb), .second_port_rst_i(rb), .second_port_addr_i(ab),
		.second_port_write_data_i(db), .second_port_read_data_o(qb));
	// same port drivers, second port eight bits wide on its own array
	dpr_dual_port_ram #(.WIDTH_B(8)) i_dpr_dual_port_ram_w8 (.clk_i(clk_i),
		.arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(), .pready_o(), .pslverr_o(),
		.first_port_clock_i(ca), .first_port_en_i(ea), .first_port_we_i(wa),
		.first_port_rst_i(ra), .first_port_addr_i(aa), .first_port_write_data_i(da),
		.first_port_read_data_o(), .second_port_clock_i(cb), .second_port_en_i(eb),
		.second_port_we_i(wb), .second_port_rst_i(rb), .second_port_addr_i({1'b0, ab}),
		.second_port_write_data_i(db[7:0]), .second_port_read_data_o(qb8));
	dpr_port_model i_port_a (.clk_i(clk_i), .pclk_o(ca), .en_o(ea), .we_o(wa), .rst_o(ra),
		.addr_o(aa), .data_o(da));
	dpr_port_model i_port_b (.clk_i(clk_i), .pclk_o(cb), .en_o(eb), .we_o(wb), .rst_o(rb),
		.addr_o(ab), .data_o(db));
	// ****
	// shared tasks
	// ****
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		// pready, data and error taken as this edge samples them
		@(posedge clk_i);
		while (pready_o !== 1'b1) begin
			@(posedge clk_i);
		end
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ****
	// scenarios
	// ****
	task s_init;
		fork
			i_port_a.op(1'b1, 1'b0, 1'b0, 8'd0, 16'h0000);
			i_port_b.op(1'b1, 1'b0, 1'b0, 8'd16, 16'h0000);
		join
		chk("init word 0", 32'h0000_A5C3, qa);
		chk("init word 16", 32'h0000_5A3C, qb);
		fork
			i_port_a.op(1'b1, 1'b0, 1'b0, 8'd240, 16'h0000);
			i_port_b.op(1'b1, 1'b0, 1'b0, 8'd32, 16'h0000);
		join
		chk("init word 240", 32'h0000_7E7E, qa);
		chk("unset word 32", 32'h0000_0000, qb);
	endtask
	task s_cross;
		i_port_b.op(1'b1, 1'b0, 1'b0, 8'd5, 16'h0000);
		chk("b old", 32'h0000_0000, qb);
		i_port_a.op(1'b1, 1'b1, 1'b0, 8'd5, 16'h9999);
		chk("a mirror", 32'h0000_9999, qa);
		chk("b kept", 32'h0000_0000, qb);
		i_port_b.op(1'b1, 1'b0, 1'b0, 8'd5, 16'h0000);
		chk("b new", 32'h0000_9999, qb);
		i_port_a.op(1'b0, 1'b1, 1'b0, 8'd5, 16'h1111);
		chk("a held", 32'h0000_9999, qa);
		i_port_b.op(1'b1, 1'b0, 1'b0, 8'd5, 16'h0000);
		chk("no disabled write", 32'h0000_9999, qb);
	endtask
	task s_rst;
		i_port_a.op(1'b1, 1'b1, 1'b0, 8'd6, 16'h1234);
		i_port_a.op(1'b1, 1'b1, 1'b1, 8'd6, 16'h4242);
		chk("a cleared", 32'h0000_0000, qa);
		i_port_a.op(1'b1, 1'b0, 1'b0, 8'd6, 16'h0000);
		chk("cell kept", 32'h0000_1234, qa);
		i_port_b.op(1'b1, 1'b0, 1'b0, 8'd13, 16'h0000);
		chk("narrow byte 13", 32'h0000_0012, qb8);
	endtask
	task s_coll;
		fork
			i_port_a.op(1'b1, 1'b1, 1'b0, 8'd7, 16'hAAAA);
			i_port_b.op(1'b1, 1'b1, 1'b0, 8'd7, 16'h5555);
		join
		chk("a own data", 32'h0000_AAAA, qa);
		chk("b own data", 32'h0000_5555, qb);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk("collision flag", 32'h0000_0001, rd);
		apb(1'b1, 12'h004, 32'h0000_0001);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk("flag cleared", 32'h0000_0000, rd);
		fork
			i_port_a.op(1'b1, 1'b1, 1'b0, 8'd8, 16'hC0DE);
			i_port_b.op(1'b1, 1'b0, 1'b0, 8'd8, 16'h0000);
		join
		chk("writer correct", 32'h0000_C0DE, qa);
		i_port_b.op(1'b1, 1'b0, 1'b0, 8'd8, 16'h0000);
		chk("write landed", 32'h0000_C0DE, qb);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk("read collision flag", 32'h0000_0002, rd);
		apb(1'b1, 12'h004, 32'h0000_0002);
	endtask
	task s_apb;
		apb(1'b0, 12'h000, 32'h0000_0000);
		chk("enable reset", 32'h0000_0001, rd);
		apb(1'b0, 12'h008, 32'h0000_0000);
		chk("window reset", 32'h0000_0002, rd);
		apb(1'b0, 12'h00C, 32'h0000_0000);
		chk("collision count", 32'h0000_0002, rd);
		apb(1'b1, 12'h008, 32'h0000_0010);
		i_port_a.op(1'b1, 1'b1, 1'b0, 8'd9, 16'h2468);
		i_port_b.op(1'b1, 1'b0, 1'b0, 8'd9, 16'h0000);
		chk("read inside window", 32'h0000_2468, qb);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk("window flag", 32'h0000_0002, rd);
		apb(1'b0, 12'h010, 32'h0000_0000);
		chk("unmapped error", 32'h0000_0001, {31'h0, er});
		chk("unmapped data", 32'h0000_0000, rd);
	endtask
	// cut a hang short
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			wrap_up;
		end
	end
	// main sequence
	initial begin
		repeat (20) @(posedge clk_i);
		arst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		s_init;
		s_cross;
		s_rst;
		s_coll;
		s_apb;
		wrap_up;
	end
endmodule // testbench
bind dpr_dual_port_ram dpr_checker #(.WIDTH_A(WIDTH_A), .WIDTH_B(WIDTH_B)) i_dpr_checker (
	.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .first_port_clock_i(first_port_clock_i),
	.first_port_en_i(first_port_en_i), .first_port_we_i(first_port_we_i),
	.first_port_rst_i(first_port_rst_i), .first_port_write_data_i(first_port_write_data_i),
	.first_port_read_data_o(first_port_read_data_o), .second_port_clock_i(second_port_clock_i),
	.second_port_en_i(second_port_en_i), .second_port_we_i(second_port_we_i),
	.second_port_rst_i(second_port_rst_i), .second_port_write_data_i(second_port_write_data_i),
	.second_port_read_data_o(second_port_read_data_o));
